/* hw/flash_ctl_pkg.sv */
package flash_ctl_pkg;
  // rewrite modes
  typedef enum logic [1:0] {
    MODE_CPU,
    MODE_SERIAL,
    MODE_PARALLEL,
    MODE_NONE
  } rewrite_mode_e;

  // software command set, eight codes
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_READ_ARRAY = 3'h0;
  localparam logic [2:0] CMD_READ_STATUS = 3'h1;
  localparam logic [2:0] CMD_CLEAR_STATUS = 3'h2;
  localparam logic [2:0] CMD_PROGRAM = 3'h3;
  localparam logic [2:0] CMD_BLOCK_ERASE = 3'h4;
  localparam logic [2:0] CMD_LOCK_BLOCK = 3'h5;
  localparam logic [2:0] CMD_READ_LOCK = 3'h6;
  localparam logic [2:0] CMD_UNLOCK_BLOCK = 3'h7;

  // address map
  localparam int ADDR_W = 20;
  localparam logic [19:0] CS2_LO = 20'h10000;
  localparam logic [19:0] CS2_HI = 20'h26FFF;
  localparam int BLOCKS = 8;
  localparam int BLK_W = 3;
  localparam logic [2:0] EXTRA_BLOCK = 3'h7;
  localparam logic [2:0] PROTECT_BLOCK = 3'h0;

  // protect configuration location fields
  localparam int PROT_LO = 6;
  localparam logic [1:0] PROT_OFF = 2'h3;
  localparam logic [5:0] PROT_LOW_FILL = 6'h3F;
  localparam logic [7:0] PROT_RESET = 8'hFF;

  // operation busy counts, plain defaults
  localparam int PROG_CYCLES = 8;
  localparam int ERASE_CYCLES = 32;
endpackage : flash_ctl_pkg

/* hw/flash_strap_if.sv */
`timescale 1ns/1ns
interface flash_strap_if;
  logic boot_mode;
  logic user_mode;
  modport src (output boot_mode, output user_mode);
  modport dst (input boot_mode, input user_mode);
endinterface : flash_strap_if

/* hw/strap_capture.sv */
`timescale 1ns/1ns
module strap_capture (
  input wire logic clk,
  input wire logic nrst,
  input wire logic processor_mode_strap,
  input wire logic boot_strap_high_pin,
  input wire logic boot_strap_low_pin,
  flash_strap_if.src strap
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s1_d;
  logic [2:0] s2_d;
  logic taken_q;
  logic taken_d;
  logic boot_q;
  logic boot_d;
  logic user_q;
  logic user_d;
  logic [1:0] armed_q;
  logic [1:0] armed_d;

  // pins are asynchronous, latch once after release
  always_comb begin
    s1_d = {processor_mode_strap, boot_strap_high_pin, boot_strap_low_pin};
    s2_d = s1_q;
    armed_d = {armed_q[0], 1'b1};
    taken_d = taken_q;
    boot_d = boot_q;
    user_d = user_q;
    // second stage still shows reset zeros until the second edge, so capture waits for the third
    if (armed_q[1] && !taken_q) begin
      taken_d = 1'b1;
      boot_d = s2_q[2] & s2_q[1] & ~s2_q[0]; // RL1 RL15
      user_d = ~s2_q[2]; // RL2 RL15
    end
  end

  // registers only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      armed_q <= 2'h0;
      taken_q <= 1'b0;
      boot_q <= 1'b0;
      user_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      armed_q <= armed_d;
      taken_q <= taken_d;
      boot_q <= boot_d;
      user_q <= user_d;
    end
  end

  assign strap.boot_mode = boot_q;
  assign strap.user_mode = user_q;
endmodule : strap_capture

/* hw/protect_decode.sv */
`timescale 1ns/1ns
module protect_decode (
  input wire logic [7:0] protect_config_location,
  output logic protect_on,
  output logic fill_ok
);
  // anything but 11b in the code field turns protection on
  assign protect_on = protect_config_location[7:flash_ctl_pkg::PROT_LO]
    != flash_ctl_pkg::PROT_OFF; // RL11
  // software is expected to fill the low six bits when enabling
  assign fill_ok = protect_config_location[5:0] == flash_ctl_pkg::PROT_LOW_FILL; // RL12
endmodule : protect_decode

/* hw/flash_boot_and_protect_control.sv */
`timescale 1ns/1ns
// Notes on behaviour
// [RL1] strap high, boot high, boot low low at reset: run from boot area
// [RL2] mode strap low at reset: run from user area
// [RL3] extra block enable opens the extra block, chip select two at 10000h-26FFFh
// [RL4] in boot mode the boot area select steers reads to boot or user area
// [RL5] boot and user areas share the same addresses
// [RL6] boot area contents never returned outside boot execution
// [RL7] boot area program and erase only in parallel mode
// [RL8] user area rewritable in cpu, serial and parallel modes
// [RL9] a locked block refuses program and erase
// [RL10] eight software commands; erase by block, program by word
// [RL11] protect code other than 11b blocks parallel read and rewrite
// [RL12] software writes low six protect bits as all ones when enabling
// [RL13] erasing the protect block in cpu or serial mode releases protection
// [RL14] cpu rewrite needs extra block enable set, code running outside flash
// [RL15] straps sampled once after reset release, held until next reset
module flash_boot_and_protect_control (
  input wire logic clk,
  input wire logic nrst,
  input wire logic processor_mode_strap,
  input wire logic boot_strap_high_pin,
  input wire logic boot_strap_low_pin,
  input wire logic extra_block_enable,
  input wire logic boot_area_select,
  input wire logic [1:0] rewrite_mode,
  input wire logic code_in_flash,
  input wire logic rd_req,
  input wire logic [19:0] rd_addr,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [19:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  output logic cmd_ready,
  output logic boot_mode,
  output logic user_mode,
  output logic cs2_select,
  output logic rd_boot_area,
  output logic rd_user_area,
  output logic rd_refused,
  output logic [2:0] rd_block,
  output logic op_busy,
  output logic op_done,
  output logic op_error,
  output logic op_program,
  output logic op_erase,
  output logic [19:0] op_addr,
  output logic [15:0] op_data,
  output logic op_boot_area,
  output logic [7:0] lock_bits,
  output logic lock_status,
  output logic protect_active,
  output logic protect_fill_ok
);
  ////////////////////////////////////////////////////////////////////////
  flash_strap_if strap ();

  strap_capture u_strap (
    .clk(clk),
    .nrst(nrst),
    .processor_mode_strap(processor_mode_strap),
    .boot_strap_high_pin(boot_strap_high_pin),
    .boot_strap_low_pin(boot_strap_low_pin),
    .strap(strap)
  );

  assign boot_mode = strap.boot_mode;
  assign user_mode = strap.user_mode;

  ////////////////////////////////////////////////////////////////////////
  // block number from address; same decode for reads and commands
  function automatic logic [2:0] block_of(input logic [19:0] a);
    logic [2:0] b;
    b = a[18:16];
    if (a >= flash_ctl_pkg::CS2_LO && a <= flash_ctl_pkg::CS2_HI) begin
      b = flash_ctl_pkg::EXTRA_BLOCK;
    end
    return b;
  endfunction : block_of

  function automatic logic in_cs2(input logic [19:0] a);
    return (a >= flash_ctl_pkg::CS2_LO) && (a <= flash_ctl_pkg::CS2_HI);
  endfunction : in_cs2

  ////////////////////////////////////////////////////////////////////////
  // protect configuration location, reloaded by erase of its block in cpu or serial mode
  logic [7:0] prot_q;
  logic [7:0] prot_d;
  logic prot_on;

  protect_decode u_prot (
    .protect_config_location(prot_q),
    .protect_on(prot_on),
    .fill_ok(protect_fill_ok)
  );

  logic parallel_m;
  logic cpu_m;
  logic serial_m;
  assign parallel_m = rewrite_mode == flash_ctl_pkg::MODE_PARALLEL;
  assign cpu_m = rewrite_mode == flash_ctl_pkg::MODE_CPU;
  assign serial_m = rewrite_mode == flash_ctl_pkg::MODE_SERIAL;
  assign protect_active = prot_on;

  ////////////////////////////////////////////////////////////////////////
  // read steering registered one cycle after rd_req
  logic rd_boot_d;
  logic rd_user_d;
  logic rd_ref_d;
  logic [2:0] rd_blk_d;
  logic cs2_d;
  logic rd_boot_q;
  logic rd_user_q;
  logic rd_ref_q;
  logic [2:0] rd_blk_q;
  logic cs2_q;

  always_comb begin
    rd_boot_d = 1'b0;
    rd_user_d = 1'b0;
    rd_ref_d = 1'b0;
    rd_blk_d = rd_blk_q;
    cs2_d = 1'b0;
    if (rd_req) begin
      rd_blk_d = block_of(rd_addr); // RL5
      cs2_d = extra_block_enable && in_cs2(rd_addr); // RL3
      if (in_cs2(rd_addr) && !extra_block_enable) begin
        rd_ref_d = 1'b1; // RL3
      end else if (parallel_m && prot_on) begin
        rd_ref_d = 1'b1; // RL11
      end else if (boot_mode && boot_area_select) begin
        rd_boot_d = 1'b1; // RL4
      end else if (boot_mode || user_mode || parallel_m) begin
        // boot contents only appear while booted, never otherwise
        rd_user_d = 1'b1; // RL4 RL6
      end else begin
        rd_user_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_boot_q <= 1'b0;
      rd_user_q <= 1'b0;
      rd_ref_q <= 1'b0;
      rd_blk_q <= 3'h0;
      cs2_q <= 1'b0;
    end else begin
      rd_boot_q <= rd_boot_d;
      rd_user_q <= rd_user_d;
      rd_ref_q <= rd_ref_d;
      rd_blk_q <= rd_blk_d;
      cs2_q <= cs2_d;
    end
  end

  assign rd_boot_area = rd_boot_q;
  assign rd_user_area = rd_user_q;
  assign rd_refused = rd_ref_q;
  assign rd_block = rd_blk_q;
  assign cs2_select = cs2_q;

  ////////////////////////////////////////////////////////////////////////
  // command sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE,
    ST_DONE
  } seq_e;

  seq_e st_q;
  seq_e st_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [7:0] lock_q;
  logic [7:0] lock_d;
  logic err_q;
  logic err_d;
  logic done_q;
  logic done_d;
  logic [19:0] addr_q;
  logic [19:0] addr_d;
  logic [15:0] data_q;
  logic [15:0] data_d;
  logic tgt_boot_q;
  logic tgt_boot_d;
  logic lstat_q;
  logic lstat_d;
  logic [2:0] cblk;
  logic allowed;

  // decide whether a rewrite may touch its target at all
  always_comb begin
    cblk = block_of(cmd_addr);
    allowed = 1'b1;
    if (cpu_m && (!extra_block_enable || code_in_flash)) begin
      allowed = 1'b0; // RL14
    end
    if (boot_mode && boot_area_select && !parallel_m) begin
      allowed = 1'b0; // RL7
    end
    if (rewrite_mode == flash_ctl_pkg::MODE_NONE) begin
      allowed = 1'b0; // RL8
    end
    if (parallel_m && prot_on) begin
      allowed = 1'b0; // RL11
    end
    if (lock_q[cblk]) begin
      allowed = 1'b0; // RL9
    end
    if (in_cs2(cmd_addr) && !extra_block_enable) begin
      allowed = 1'b0; // RL3
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    lock_d = lock_q;
    err_d = err_q;
    done_d = 1'b0;
    addr_d = addr_q;
    data_d = data_q;
    tgt_boot_d = tgt_boot_q;
    lstat_d = lstat_q;
    prot_d = prot_q;
    case (st_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          case (cmd_code) // RL10
            flash_ctl_pkg::CMD_PROGRAM: begin
              addr_d = cmd_addr;
              data_d = cmd_data;
              tgt_boot_d = boot_mode && boot_area_select;
              if (allowed) begin
                st_d = ST_PROG; // RL8
                cnt_d = 6'(flash_ctl_pkg::PROG_CYCLES - 1);
              end else begin
                err_d = 1'b1;
              end
            end
            flash_ctl_pkg::CMD_BLOCK_ERASE: begin
              addr_d = cmd_addr;
              tgt_boot_d = boot_mode && boot_area_select;
              if (allowed) begin
                st_d = ST_ERASE; // RL10
                cnt_d = 6'(flash_ctl_pkg::ERASE_CYCLES - 1);
              end else begin
                err_d = 1'b1;
              end
            end
            flash_ctl_pkg::CMD_LOCK_BLOCK: lock_d[cblk] = 1'b1; // RL9
            flash_ctl_pkg::CMD_UNLOCK_BLOCK: lock_d[cblk] = 1'b0;
            flash_ctl_pkg::CMD_READ_LOCK: lstat_d = lock_q[cblk];
            flash_ctl_pkg::CMD_CLEAR_STATUS: err_d = 1'b0;
            default: ;
          endcase
        end
      end
      ST_PROG: begin
        // protect word takes any user-area program into the protect block, whatever its offset
        if (cnt_q == 6'h0) begin
          if (block_of(addr_q) == flash_ctl_pkg::PROTECT_BLOCK && !tgt_boot_q) begin
            prot_d = prot_q & data_q[7:0]; // flash bits only clear
          end
          st_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - 6'h1;
        end
      end
      ST_ERASE: begin
        if (cnt_q == 6'h0) begin
          if (block_of(addr_q) == flash_ctl_pkg::PROTECT_BLOCK && !tgt_boot_q
              && (cpu_m || serial_m)) begin
            prot_d = flash_ctl_pkg::PROT_RESET; // RL13
          end
          st_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - 6'h1;
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      cnt_q <= 6'h0;
      lock_q <= 8'h00;
      err_q <= 1'b0;
      done_q <= 1'b0;
      addr_q <= 20'h00000;
      data_q <= 16'h0000;
      tgt_boot_q <= 1'b0;
      lstat_q <= 1'b0;
      prot_q <= flash_ctl_pkg::PROT_RESET;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lock_q <= lock_d;
      err_q <= err_d;
      done_q <= done_d;
      addr_q <= addr_d;
      data_q <= data_d;
      tgt_boot_q <= tgt_boot_d;
      lstat_q <= lstat_d;
      prot_q <= prot_d;
    end
  end

  assign cmd_ready = st_q == ST_IDLE;
  assign op_busy = (st_q == ST_PROG) || (st_q == ST_ERASE);
  assign op_program = st_q == ST_PROG;
  assign op_erase = st_q == ST_ERASE;
  assign op_done = done_q;
  assign op_error = err_q;
  assign op_addr = addr_q;
  assign op_data = data_q;
  assign op_boot_area = tgt_boot_q;
  assign lock_bits = lock_q;
  assign lock_status = lstat_q;
endmodule : flash_boot_and_protect_control

/* test/flash_host_model.sv */
`timescale 1ns/1ns
// command source standing in for cpu software or an outside programmer
module flash_host_model (
  input wire logic clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [19:0] cmd_addr,
  output logic [15:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_addr = 20'h00000;
    cmd_data = 16'h0000;
  end
  // hold the request until ready is seen at an edge; released lines flip
  task automatic send(input logic [2:0] code, input logic [19:0] addr, input logic [15:0] data);
    logic [15:0] d;
    d = data;
    if (code == flash_ctl_pkg::CMD_PROGRAM && addr[18:16] == flash_ctl_pkg::PROTECT_BLOCK) begin
      d[5:0] = flash_ctl_pkg::PROT_LOW_FILL;
    end
    @(posedge clk);
    #10;
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_addr = addr;
    cmd_data = d;
    // ready moves only on edges, so its settled value names the coming edge
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #10;
    end
    @(posedge clk);
    #10;
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_addr = ~addr;
    cmd_data = ~d;
  endtask : send
endmodule : flash_host_model

/* test/flash_ctl_chk.sv */
`timescale 1ns/1ns
module flash_ctl_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic boot_mode,
  input wire logic user_mode,
  input wire logic boot_area_select,
  input wire logic [1:0] rewrite_mode,
  input wire logic extra_block_enable,
  input wire logic code_in_flash,
  input wire logic rd_req,
  input wire logic rd_boot_area,
  input wire logic rd_refused,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_code,
  input wire logic [19:0] cmd_addr,
  input wire logic op_program,
  input wire logic op_erase,
  input wire logic op_done,
  input wire logic op_error,
  input wire logic op_busy,
  input wire logic [7:0] lock_bits,
  input wire logic protect_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic acc;
  logic [1:0] up_q;
  // rewrite request taken this edge
  assign acc = cmd_valid && cmd_ready &&
    (cmd_code == flash_ctl_pkg::CMD_PROGRAM || cmd_code == flash_ctl_pkg::CMD_BLOCK_ERASE);
  // edges since reset release; straps settle on the third
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_mode_excl: assert property (!(boot_mode && user_mode)) else $error("both modes");
  chk_strap_hold: assert property (up_q == 2'h3 && $past(up_q) == 2'h3 |->
    $stable(boot_mode) && $stable(user_mode)) else $error("mode moved");
  chk_boot_hidden: assert property (rd_boot_area |-> boot_mode) else $error("boot read");
  chk_steer_user: assert property (rd_req && boot_mode && !boot_area_select |=>
    !rd_boot_area) else $error("steer");
  chk_prog_len: assert property ($rose(op_program) |-> op_program [*8] ##1
    (!op_program && !op_done) ##1 op_done) else $error("program len");
  chk_erase_len: assert property ($rose(op_erase) |-> ##31 op_erase ##1 !op_erase
    ##1 op_done) else $error("erase len");
  chk_lock_refuse: assert property (acc && lock_bits[cmd_addr[18:16]] |=>
    op_error && !op_busy) else $error("lock");
  chk_boot_rewrite: assert property (acc && boot_mode && boot_area_select &&
    rewrite_mode != flash_ctl_pkg::MODE_PARALLEL |=> op_error && !op_busy)
    else $error("boot write");
  chk_prot_write: assert property (acc && protect_active &&
    rewrite_mode == flash_ctl_pkg::MODE_PARALLEL |=> op_error) else $error("prot wr");
  chk_prot_read: assert property (rd_req && protect_active &&
    rewrite_mode == flash_ctl_pkg::MODE_PARALLEL |=> rd_refused) else $error("prot rd");
  chk_cpu_guard: assert property (acc && rewrite_mode == flash_ctl_pkg::MODE_CPU &&
    (!extra_block_enable || code_in_flash) |=> op_error) else $error("cpu guard");
  cov_prog: cover property (op_done);
  cov_refuse: cover property ($rose(op_error));
  cov_boot_rd: cover property (rd_boot_area);
endmodule : flash_ctl_chk
bind flash_boot_and_protect_control flash_ctl_chk i_chk (.clk, .nrst, .boot_mode, .user_mode,
  .boot_area_select, .rewrite_mode, .extra_block_enable, .code_in_flash, .rd_req, .rd_boot_area,
  .rd_refused, .cmd_valid, .cmd_ready, .cmd_code, .cmd_addr, .op_program, .op_erase, .op_done,
  .op_error, .op_busy, .lock_bits, .protect_active);

/* test/flash_boot_and_protect_control_bench.sv */
`timescale 1ns/1ns
module flash_boot_and_protect_control_bench;
  logic clk, nrst, processor_mode_strap, boot_strap_high_pin, boot_strap_low_pin;
  logic extra_block_enable, boot_area_select, code_in_flash, rd_req, cmd_valid, cmd_ready;
  logic boot_mode, user_mode, cs2_select, rd_boot_area, rd_user_area, rd_refused, op_busy;
  logic op_done, op_error, op_program, op_erase, op_boot_area, lock_status, protect_active;
  logic protect_fill_ok;
  logic [1:0] rewrite_mode;
  logic [2:0] cmd_code, rd_block;
  logic [19:0] rd_addr, cmd_addr, op_addr, a;
  logic [15:0] cmd_data, op_data;
  logic [7:0] lock_bits;
  logic [31:0] rnd_state, r;
  int bad_count, cmp_count, cycles, i;
  flash_boot_and_protect_control i_dut (.clk, .nrst, .processor_mode_strap,
    .boot_strap_high_pin, .boot_strap_low_pin, .extra_block_enable, .boot_area_select,
    .rewrite_mode, .code_in_flash, .rd_req, .rd_addr, .cmd_valid, .cmd_code, .cmd_addr,
    .cmd_data, .cmd_ready, .boot_mode, .user_mode, .cs2_select, .rd_boot_area, .rd_user_area,
    .rd_refused, .rd_block, .op_busy, .op_done, .op_error, .op_program, .op_erase, .op_addr,
    .op_data, .op_boot_area, .lock_bits, .lock_status, .protect_active, .protect_fill_ok);
  flash_host_model i_host (.clk, .cmd_ready, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data);
  ////////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xorshift();
    rnd_state ^= rnd_state << 13;
    rnd_state ^= rnd_state >> 17;
    rnd_state ^= rnd_state << 5;
    return rnd_state;
  endfunction : xorshift
  task automatic chk(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk
  task automatic chkv(input logic [19:0] got, input logic [19:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chkv
  task automatic do_reset(input logic [2:0] s);
    nrst = 1'b0;
    {processor_mode_strap, boot_strap_high_pin, boot_strap_low_pin} = s;
    repeat (4) @(posedge clk);
    #10 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #10;
  endtask : do_reset
  // read answer stands right after the taking edge; the flags for that one cycle only, rd_block holds until the next read
  task automatic rd(input logic [19:0] ad);
    @(posedge clk);
    #10 rd_req = 1'b1;
    rd_addr = ad;
    @(posedge clk);
    #10 rd_req = 1'b0;
    rd_addr = ~ad;
  endtask : rd
  // one command; refused ones are followed by a status clear
  task automatic op(input logic [2:0] c, input logic [19:0] ad, input logic [15:0] d,
                    input logic err);
    int n;
    i_host.send(c, ad, d);
    chk(op_error, err, "error flag");
    if (!err && (c == flash_ctl_pkg::CMD_PROGRAM || c == flash_ctl_pkg::CMD_BLOCK_ERASE)) begin
      chk(op_busy, 1'b1, "busy");
      chkv(op_addr, ad, "target");
      // erase carries no word, the data register keeps the last program
      if (c == flash_ctl_pkg::CMD_PROGRAM) chkv({4'h0, op_data}, {4'h0, d}, "word");
      n = 0;
      while (op_done !== 1'b1 && n < 60) begin
        @(posedge clk);
        #10 n++;
      end
      chk(n < 60, 1'b1, "no done");
    end
    if (err) i_host.send(flash_ctl_pkg::CMD_CLEAR_STATUS, 20'h00000, 16'h0000);
  endtask : op
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, nrst, rd_req, boot_area_select, code_in_flash} = 5'h00;
    extra_block_enable = 1'b1;
    rewrite_mode = flash_ctl_pkg::MODE_CPU;
    rd_addr = 20'h00000;
    rnd_state = 32'h94722B33;
    for (i = 0; i < 8; i++) begin
      do_reset(i[2:0]);
      chk(boot_mode, i == 6, "boot strap");
      chk(user_mode, !i[2], "user strap");
      {processor_mode_strap, boot_strap_high_pin, boot_strap_low_pin} = ~i[2:0];
      repeat (4) @(posedge clk);
      #10 chk(boot_mode, i == 6, "strap held");
    end
    $display("test straps done");
    do_reset(3'h6);
    repeat (40) begin
      r = xorshift();
      boot_area_select = r[20];
      a = {4'h3 + {2'h0, r[17:16]}, r[15:0]};
      rd(a);
      chk(rd_boot_area, r[20], "boot steer");
      chk(rd_user_area, !r[20], "user steer");
      chkv({17'h0, rd_block}, {17'h0, a[18:16]}, "block");
    end
    for (i = 0; i < 2; i++) begin
      extra_block_enable = i[0];
      rd(20'h26FFF);
      chk(rd_refused, !i[0], "extra block");
      chk(cs2_select, i[0], "cs2 select");
    end
    $display("test reads done");
    boot_area_select = 1'b0;
    for (i = 0; i < 3; i++) begin
      rewrite_mode = i[1:0];
      r = xorshift();
      op(flash_ctl_pkg::CMD_PROGRAM, {4'h3 + i[3:0], r[15:0]}, r[31:16], 1'b0);
    end
    op(flash_ctl_pkg::CMD_BLOCK_ERASE, 20'h50000, 16'h0000, 1'b0);
    chk(op_boot_area, 1'b0, "user target");
    boot_area_select = 1'b1;
    for (i = 0; i < 3; i++) begin
      rewrite_mode = i[1:0];
      op(flash_ctl_pkg::CMD_PROGRAM, 20'h30010, 16'h1234, i != 2);
    end
    chk(op_boot_area, 1'b1, "boot target");
    boot_area_select = 1'b0;
    rewrite_mode = flash_ctl_pkg::MODE_CPU;
    op(flash_ctl_pkg::CMD_LOCK_BLOCK, 20'h40000, 16'h0000, 1'b0);
    chk(lock_bits[4], 1'b1, "locked");
    op(flash_ctl_pkg::CMD_PROGRAM, 20'h40002, 16'hA5A5, 1'b1);
    op(flash_ctl_pkg::CMD_BLOCK_ERASE, 20'h40000, 16'h0000, 1'b1);
    op(flash_ctl_pkg::CMD_READ_LOCK, 20'h40000, 16'h0000, 1'b0);
    chk(lock_status, 1'b1, "lock status set");
    op(flash_ctl_pkg::CMD_UNLOCK_BLOCK, 20'h40000, 16'h0000, 1'b0);
    chk(lock_bits[4], 1'b0, "unlocked");
    op(flash_ctl_pkg::CMD_READ_LOCK, 20'h40000, 16'h0000, 1'b0);
    chk(lock_status, 1'b0, "lock status clear");
    op(flash_ctl_pkg::CMD_READ_ARRAY, 20'h40000, 16'h0000, 1'b0);
    op(flash_ctl_pkg::CMD_READ_STATUS, 20'h40000, 16'h0000, 1'b0);
    op(flash_ctl_pkg::CMD_PROGRAM, 20'h40002, 16'hA5A5, 1'b0);
    extra_block_enable = 1'b0;
    op(flash_ctl_pkg::CMD_PROGRAM, 20'h40004, 16'h0001, 1'b1);
    extra_block_enable = 1'b1;
    code_in_flash = 1'b1;
    op(flash_ctl_pkg::CMD_PROGRAM, 20'h40004, 16'h0001, 1'b1);
    code_in_flash = 1'b0;
    $display("test rewrites done");
    op(flash_ctl_pkg::CMD_PROGRAM, 20'h00000, 16'h003F, 1'b0);
    chk(protect_active, 1'b1, "protect on");
    chk(protect_fill_ok, 1'b1, "fill");
    rewrite_mode = flash_ctl_pkg::MODE_PARALLEL;
    op(flash_ctl_pkg::CMD_PROGRAM, 20'h30000, 16'h0001, 1'b1);
    rd(20'h30000);
    chk(rd_refused, 1'b1, "protect read");
    op(flash_ctl_pkg::CMD_BLOCK_ERASE, 20'h00000, 16'h0000, 1'b1);
    rewrite_mode = flash_ctl_pkg::MODE_SERIAL;
    op(flash_ctl_pkg::CMD_BLOCK_ERASE, 20'h00000, 16'h0000, 1'b0);
    chk(protect_active, 1'b0, "protect off");
    $display("test protect done");
    do_reset(3'h0);
    repeat (20) begin
      r = xorshift();
      boot_area_select = r[0];
      rd({4'h3, r[15:0]});
      chk(rd_boot_area, 1'b0, "boot hidden");
      chk(rd_user_area, 1'b1, "user read");
    end
    $display("test user mode done");
    end_of_test();
  end
endmodule : flash_boot_and_protect_control_bench
